// file: design/ldmc_defs.svh
// Timing counts, codes and limits for the dimming mode controller
// Assumes a 20 MHz ref_clk
`ifndef LDMC_DEFS_SVH
`define LDMC_DEFS_SVH
`define LDMC_CLK_MHZ        20
`define LDMC_UNDERVOLTAGE_LOCKOUT_DELAY_US  1000
`define LDMC_UNDERVOLTAGE_LOCKOUT_DELAY_CYC (`LDMC_UNDERVOLTAGE_LOCKOUT_DELAY_US * `LDMC_CLK_MHZ)
`define LDMC_REEN_DELAY_US  300
`define LDMC_REEN_DELAY_CYC (`LDMC_REEN_DELAY_US * `LDMC_CLK_MHZ)
`define LDMC_RAMP_US        5000
`define LDMC_RAMP_STEP_CYC  ((`LDMC_RAMP_US * `LDMC_CLK_MHZ) / 256)
`define LDMC_PULSE_MIN_NS   150
`define LDMC_CLK_NS         50
`define LDMC_DETECT_CYC     64
`define LDMC_REF_FULL       8'h00FF
`define LDMC_HYB_KNEE       8'h0020
`define LDMC_HYST_CODE      8'h0001
`define LDMC_CNT_W          16
`endif

// file: design/ldmc_pkg.sv
// Types shared by the dimming mode controller
// Assumes nothing beyond the defines header
package ldmc_pkg;
  typedef enum logic [2:0] {
    LDMC_ST_OFF    = 3'b000,
    LDMC_ST_WAIT   = 3'b001,
    LDMC_ST_DETECT = 3'b010,
    LDMC_ST_RUN    = 3'b011
  } ldmc_state_t;
  typedef enum logic [1:0] {
    LDMC_MODE_PWM    = 2'b00,
    LDMC_MODE_ANALOG = 2'b01,
    LDMC_MODE_HYBRID = 2'b10,
    LDMC_MODE_FLEX   = 2'b11
  } ldmc_mode_t;
endpackage

// file: design/ldmc_duty_if.sv
// Duty measurement results from a meter to the controller
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface ldmc_duty_if;
  logic       done;
  logic [7:0] code;
  logic       toggled;
  modport meter (output done, output code, output toggled);
  modport ctrl  (input done, input code, input toggled);
endinterface

// file: design/ldmc_duty_meter.sv
// Duty meter: counts high time and period of one input
// Assumes the input is synchronous to ref_clk
`timescale 1ns/1ps
`include "ldmc_defs.svh"
module ldmc_duty_meter import ldmc_pkg::*; #(
  parameter int CNT_W = `LDMC_CNT_W
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic sig_in,
  ldmc_duty_if.meter duty
);
  logic             sig_d_reg;
  logic [CNT_W-1:0] per_reg;
  logic [CNT_W-1:0] high_reg;
  logic             done_reg;
  logic [7:0]       code_reg;
  logic             rise;
  logic [CNT_W+7:0] scaled;
  assign rise = sig_in & ~sig_d_reg;
  assign scaled = ({8'h00, high_reg} << 8) - {8'h00, high_reg};

  // ------------------------------------------------------------
  // Counting
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sig_d_reg <= 1'b0;
      per_reg   <= '0;
      high_reg  <= '0;
      done_reg  <= 1'b0;
      code_reg  <= 8'h0000;
    end else begin
      sig_d_reg <= sig_in;
      done_reg  <= 1'b0;
      if (rise) begin
        done_reg <= 1'b1;
        if (per_reg != '0)
          code_reg <= 8'((scaled / {8'h00, per_reg}));
        per_reg  <= CNT_W'(1);
        high_reg <= CNT_W'(1);
      end else begin
        if (~&per_reg)
          per_reg <= per_reg + CNT_W'(1);
        if (sig_in && ~&high_reg)
          high_reg <= high_reg + CNT_W'(1);
      end
    end
  end
  assign duty.done    = done_reg;
  assign duty.code    = code_reg;
  assign duty.toggled = sig_in ^ sig_d_reg;

  property p_code_half;
    @(posedge ref_clk) disable iff (rst)
    (rise && per_reg != '0 && per_reg == {high_reg[CNT_W-2:0], 1'b0}) |=> code_reg == 8'h007F;
  endproperty
  a_code_half: assert property (p_code_half)
    else $error("half duty not coded as mid scale");
  property p_done_pulse;
    @(posedge ref_clk) disable iff (rst)
    rise |=> done_reg ##1 !done_reg;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done not a single pulse after rise");
endmodule

// file: design/ldmc_core.sv
// Dimming mode controller: start-up, mode select, reference, gating, faults
// Assumes synchronous pins and comparator levels on ref_clk
`timescale 1ns/1ps
`include "ldmc_defs.svh"
module ldmc_core import ldmc_pkg::*; #(
  parameter int UNDERVOLTAGE_LOCKOUT_DELAY_CYC = `LDMC_UNDERVOLTAGE_LOCKOUT_DELAY_CYC,
  parameter int REEN_DELAY_CYC = `LDMC_REEN_DELAY_CYC,
  parameter int RAMP_STEP_CYC  = `LDMC_RAMP_STEP_CYC,
  parameter int DETECT_CYC     = `LDMC_DETECT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       enable_pwm_in,
  input  wire logic       level_dim_select_input,
  input  wire logic       undervoltage_lockout,
  input  wire logic       feedback_above_cv,
  input  wire logic       feedback_open_load,
  input  wire logic       sense_overdrive,
  input  wire logic       comp_clamped_switch,
  input  wire logic       comp_clamped_sense,
  input  wire logic       led_short_margin,
  input  wire logic       thermal_over,
  output logic            switch_enable,
  output logic            cv_active,
  output logic [7:0]      current_ref_code,
  output logic            fault_n_out,
  output logic            fault_n_oe,
  output ldmc_mode_t      dim_mode,
  output logic            dim_running
);
  localparam int CYC_W = 32;

  ldmc_duty_if en_duty ();
  ldmc_duty_if dim_duty ();

  ldmc_state_t      state_reg;
  ldmc_mode_t       mode_reg;
  logic [CYC_W-1:0] cnt_reg;
  logic             undervoltage_lockout_d_reg;
  logic             was_on_reg;
  logic             en_tog_reg;
  logic             dim_tog_reg;
  logic             dim_seen_reg;
  logic [1:0]       dim_per_reg;
  logic             ramp_reg;
  logic [CYC_W-1:0] ramp_cnt_reg;
  logic [7:0]       ref_reg;
  logic             low_bright_reg;
  logic             sw_reg;
  logic             cv_reg;
  logic             fault_stop;
  logic             fault_any;
  logic             fault_reg;
  logic             stop_reg;
  logic             gate;
  logic             hyb_gate;

  ldmc_duty_meter u_en_meter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sig_in  (enable_pwm_in),
    .duty    (en_duty.meter)
  );

  ldmc_duty_meter u_dim_meter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sig_in  (level_dim_select_input),
    .duty    (dim_duty.meter)
  );

  // ------------------------------------------------------------
  // Start-up and mode detection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg   <= LDMC_ST_OFF;
      mode_reg    <= LDMC_MODE_PWM;
      cnt_reg     <= '0;
      undervoltage_lockout_d_reg  <= 1'b1;
      was_on_reg  <= 1'b0;
      en_tog_reg  <= 1'b0;
      dim_tog_reg <= 1'b0;
    end else begin
      undervoltage_lockout_d_reg <= undervoltage_lockout;
      if (undervoltage_lockout) begin
        state_reg  <= LDMC_ST_OFF;
        was_on_reg <= 1'b0;
      end else begin
        case (state_reg)
          LDMC_ST_OFF: begin
            if (undervoltage_lockout_d_reg || enable_pwm_in) begin
              cnt_reg   <= '0;
              state_reg <= LDMC_ST_WAIT;
            end
          end
          LDMC_ST_WAIT: begin
            cnt_reg <= cnt_reg + CYC_W'(1);
            if (cnt_reg + CYC_W'(1) >= CYC_W'(was_on_reg ? REEN_DELAY_CYC : UNDERVOLTAGE_LOCKOUT_DELAY_CYC)) begin
              cnt_reg     <= '0;
              en_tog_reg  <= 1'b0;
              dim_tog_reg <= 1'b0;
              state_reg   <= LDMC_ST_DETECT;
            end
          end
          LDMC_ST_DETECT: begin
            cnt_reg <= cnt_reg + CYC_W'(1);
            if (en_duty.toggled)
              en_tog_reg <= 1'b1;
            if (dim_duty.toggled)
              dim_tog_reg <= 1'b1;
            if (cnt_reg + CYC_W'(1) >= CYC_W'(DETECT_CYC)) begin
              state_reg <= LDMC_ST_RUN;
              if (en_tog_reg && dim_tog_reg)
                mode_reg <= LDMC_MODE_FLEX;
              else if (dim_tog_reg)
                mode_reg <= LDMC_MODE_ANALOG;
              else if (level_dim_select_input)
                mode_reg <= LDMC_MODE_PWM;
              else
                mode_reg <= LDMC_MODE_HYBRID;
            end
          end
          LDMC_ST_RUN: begin
            was_on_reg <= 1'b1;
            if (mode_reg == LDMC_MODE_ANALOG && !enable_pwm_in)
              state_reg <= LDMC_ST_OFF;
          end
          default: state_reg <= LDMC_ST_OFF;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Current reference with initial ramp in analog and flexible modes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg != LDMC_ST_RUN) begin
      dim_seen_reg <= 1'b0;
      dim_per_reg  <= 2'b00;
      ramp_reg     <= 1'b1;
      ramp_cnt_reg <= '0;
      ref_reg      <= 8'h0000;
    end else if (mode_reg == LDMC_MODE_ANALOG || mode_reg == LDMC_MODE_FLEX) begin
      if (dim_duty.done) begin
        dim_seen_reg <= 1'b1;
        if (dim_per_reg != 2'b11)
          dim_per_reg <= dim_per_reg + 2'b01;
      end
      if (ramp_reg && dim_seen_reg) begin
        ramp_cnt_reg <= ramp_cnt_reg + CYC_W'(1);
        if (ramp_cnt_reg + CYC_W'(1) >= CYC_W'(RAMP_STEP_CYC)) begin
          ramp_cnt_reg <= '0;
          if (ref_reg != `LDMC_REF_FULL)
            ref_reg <= ref_reg + 8'h0001;
        end
        if (dim_duty.done && dim_per_reg == 2'b10)
          ramp_reg <= 1'b0;
      end else if (!ramp_reg && dim_duty.done) begin
        ref_reg <= dim_duty.code;
      end
    end else if (mode_reg == LDMC_MODE_HYBRID) begin
      ramp_reg <= 1'b0;
      if (en_duty.done) begin
        if (en_duty.code >= `LDMC_HYB_KNEE)
          ref_reg <= en_duty.code;
        else
          ref_reg <= `LDMC_HYB_KNEE;
      end
    end else begin
      ramp_reg <= 1'b0;
      ref_reg  <= `LDMC_REF_FULL;
    end
  end

  // ------------------------------------------------------------
  // Hybrid low-brightness decision with hysteresis
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_bright_reg <= 1'b0;
    end else if (en_duty.done) begin
      if (low_bright_reg && en_duty.code >= `LDMC_HYB_KNEE + `LDMC_HYST_CODE)
        low_bright_reg <= 1'b0;
      else if (!low_bright_reg && en_duty.code < `LDMC_HYB_KNEE)
        low_bright_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Switch gating, constant voltage and faults
  // ------------------------------------------------------------
  assign hyb_gate = low_bright_reg ? enable_pwm_in : 1'b1;
  always_comb begin
    gate = 1'b0;
    case (mode_reg)
      LDMC_MODE_PWM:    gate = enable_pwm_in;
      LDMC_MODE_ANALOG: gate = 1'b1;
      LDMC_MODE_HYBRID: gate = hyb_gate;
      LDMC_MODE_FLEX:   gate = enable_pwm_in;
      default:          gate = 1'b0;
    endcase
  end
  assign fault_stop = feedback_open_load | sense_overdrive | comp_clamped_switch | thermal_over;
  assign fault_any  = fault_stop | led_short_margin | comp_clamped_sense;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_reg <= 1'b0;
      stop_reg  <= 1'b0;
      cv_reg    <= 1'b0;
      sw_reg    <= 1'b0;
    end else begin
      fault_reg <= fault_any;
      stop_reg  <= fault_stop;
      cv_reg    <= feedback_above_cv;
      sw_reg    <= (state_reg == LDMC_ST_RUN) && gate && !fault_stop;
    end
  end

  assign switch_enable    = sw_reg;
  assign cv_active        = cv_reg;
  assign current_ref_code = ref_reg;
  assign fault_n_out      = 1'b0;
  assign fault_n_oe       = ~fault_reg;
  assign dim_mode         = mode_reg;
  assign dim_running      = (state_reg == LDMC_ST_RUN);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pwm_on;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_PWM && enable_pwm_in && !fault_stop) |=> switch_enable;
  endproperty
  a_pwm_on: assert property (p_pwm_on)
    else $error("switch not on after enable high");
  property p_pwm_off;
    @(posedge ref_clk) disable iff (rst)
    (mode_reg == LDMC_MODE_PWM && !enable_pwm_in) |=> !switch_enable;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("switch on while enable low");
  property p_narrow;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_PWM && !fault_stop && $rose(enable_pwm_in))
    |=> switch_enable;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow pulse missed");
  property p_stop;
    @(posedge ref_clk) disable iff (rst)
    fault_stop |=> !switch_enable && !fault_n_oe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopping fault did not stop switching");
  property p_flag_only;
    @(posedge ref_clk) disable iff (rst)
    (led_short_margin && !fault_stop && state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_ANALOG
     && $stable(state_reg)) |=> !fault_n_oe && switch_enable;
  endproperty
  a_flag_only: assert property (p_flag_only)
    else $error("flag-only fault changed switching");
  property p_release;
    @(posedge ref_clk) disable iff (rst)
    !fault_any |=> fault_n_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("fault output held with no fault");
  property p_cv;
    @(posedge ref_clk) disable iff (rst)
    feedback_above_cv |=> cv_active;
  endproperty
  a_cv: assert property (p_cv)
    else $error("constant voltage not entered");
  property p_thermal;
    @(posedge ref_clk) disable iff (rst)
    thermal_over ##1 thermal_over |-> !switch_enable;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("switching during thermal shutdown");
  property p_hyb_fix;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_HYBRID && en_duty.done && en_duty.code < 8'h0020)
    |=> current_ref_code == 8'h0020;
  endproperty
  a_hyb_fix: assert property (p_hyb_fix)
    else $error("hybrid low reference not fixed");
  property p_wait_len;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_DETECT && $past(state_reg) == LDMC_ST_WAIT)
    |-> $past(cnt_reg) == CYC_W'(was_on_reg ? REEN_DELAY_CYC : UNDERVOLTAGE_LOCKOUT_DELAY_CYC) - CYC_W'(1);
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("start delay length wrong");
  property p_hyb_track;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_HYBRID && en_duty.done && en_duty.code >= 8'h0020)
    |=> current_ref_code == $past(en_duty.code);
  endproperty
  a_hyb_track: assert property (p_hyb_track)
    else $error("hybrid reference not tracking duty");
  property p_flex_gate;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && mode_reg == LDMC_MODE_FLEX && !fault_stop) |=> switch_enable == $past(enable_pwm_in);
  endproperty
  a_flex_gate: assert property (p_flex_gate)
    else $error("flexible gating not following enable");
  property p_follow;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && (mode_reg == LDMC_MODE_ANALOG || mode_reg == LDMC_MODE_FLEX) && !ramp_reg
     && dim_duty.done) |=> current_ref_code == $past(dim_duty.code);
  endproperty
  a_follow: assert property (p_follow)
    else $error("reference not following dim duty");
  property p_ramp_step;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == LDMC_ST_RUN && (mode_reg == LDMC_MODE_ANALOG || mode_reg == LDMC_MODE_FLEX) && ramp_reg)
    |=> 8'(current_ref_code - $past(ref_reg)) <= 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp moved more than one step");
endmodule

// file: verif/ldmc_host_model.sv
// Host model: drives the enable and dim pins per mode
// Assumes ref_clk shared with the controller
`timescale 1ns/1ps
module ldmc_host_model import ldmc_pkg::*; #(
  parameter int PERIOD = 64
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire ldmc_mode_t mode,
  input  wire logic [7:0] en_high,
  input  wire logic [7:0] dim_high,
  output logic            enable_pwm_in,
  output logic            level_dim_select_input
);
  logic [7:0] cnt_reg;
  logic [7:0] init_reg;
  logic       en_p;
  logic       dim_p;
  // ----------------------------------------
  // Period and start-up counters
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || !go) begin
      cnt_reg  <= 8'h00;
      init_reg <= 8'h00;
    end else begin
      cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
      if (!init_reg[7]) begin
        init_reg <= init_reg + 8'h01;
      end
    end
  end
  // ----------------------------------------
  // Pin patterns
  // ----------------------------------------
  assign en_p  = !init_reg[7] || (cnt_reg < en_high);
  assign dim_p = cnt_reg < dim_high;
  always_comb begin
    enable_pwm_in          = 1'b0;
    level_dim_select_input = 1'b0;
    if (go) begin
      case (mode)
        LDMC_MODE_PWM: begin
          enable_pwm_in          = en_p;
          level_dim_select_input = 1'b1;
        end
        LDMC_MODE_ANALOG: begin
          enable_pwm_in          = 1'b1;
          level_dim_select_input = dim_p;
        end
        LDMC_MODE_HYBRID: begin
          enable_pwm_in = en_p;
        end
        default: begin
          enable_pwm_in          = en_p;
          level_dim_select_input = dim_p;
        end
      endcase
    end
  end
endmodule

// file: verif/test_led_dimming_mode_controller.sv
// Testbench for the dimming mode controller
// Assumes shortened start-up and ramp counts
`timescale 1ns/1ps
`include "ldmc_defs.svh"
module test_led_dimming_mode_controller import ldmc_pkg::*; ;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       undervoltage_lockout = 1'b1;
  logic       fb_cv = 1'b0;
  logic [5:0] fault_vec = 6'h00;
  logic       go = 1'b0;
  ldmc_mode_t mode = LDMC_MODE_PWM;
  logic [7:0] en_h = 8'h00;
  logic [7:0] dim_h = 8'h00;
  logic       enable_pwm_in;
  logic       level_dim_select_input;
  logic       switch_enable;
  logic       cv_active;
  logic [7:0] current_ref_code;
  logic       fault_n_out;
  logic       fault_n_oe;
  ldmc_mode_t dim_mode;
  logic       dim_running;
  int         n_mismatch = 0;
  int         tests_run = 0;
  localparam int UNDERVOLTAGE_LOCKOUT_CYC = 200;
  localparam int REEN_CYC = 60;
  localparam int DET_CYC  = 64;
  initial forever #25 ref_clk = ~ref_clk;
  ldmc_host_model host (.ref_clk(ref_clk), .rst(rst), .go(go), .mode(mode), .en_high(en_h), .dim_high(dim_h),
    .enable_pwm_in(enable_pwm_in), .level_dim_select_input(level_dim_select_input));
  ldmc_core #(.UNDERVOLTAGE_LOCKOUT_DELAY_CYC(UNDERVOLTAGE_LOCKOUT_CYC), .REEN_DELAY_CYC(REEN_CYC), .RAMP_STEP_CYC(4), .DETECT_CYC(DET_CYC)) DUT (
    .ref_clk(ref_clk), .rst(rst), .enable_pwm_in(enable_pwm_in), .level_dim_select_input(level_dim_select_input),
    .undervoltage_lockout(undervoltage_lockout), .feedback_above_cv(fb_cv), .feedback_open_load(fault_vec[0]),
    .sense_overdrive(fault_vec[1]), .comp_clamped_switch(fault_vec[2]), .comp_clamped_sense(fault_vec[3]),
    .led_short_margin(fault_vec[4]), .thermal_over(fault_vec[5]), .switch_enable(switch_enable),
    .cv_active(cv_active), .current_ref_code(current_ref_code), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .dim_mode(dim_mode), .dim_running(dim_running));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_run(input int exp_cyc);
    int i;
    for (i = 0; i < 1000 && dim_running !== 1'b1; i++) @(posedge ref_clk);
    if (i == 1000) begin
      check(8'h00, 8'h01, "start timeout");
      close_out();
    end
    check(8'(i - exp_cyc), 8'h00, "start delay");
  endtask
  task automatic start(input ldmc_mode_t m, input logic [7:0] eh, input logic [7:0] dh);
    @(posedge ref_clk);
    rst <= 1'b1;
    go <= 1'b0;
    undervoltage_lockout <= 1'b1;
    mode <= m;
    en_h <= eh;
    dim_h <= dh;
    repeat (10) @(posedge ref_clk);
    #1 check(current_ref_code, 8'h00, "reset reference");
    check(8'({switch_enable, fault_n_out, cv_active, dim_running}), 8'h00, "reset outputs");
    check(8'({fault_n_oe, dim_mode}), 8'h04, "reset fault and mode");
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    go <= 1'b1;
    undervoltage_lockout <= 1'b0;
    wait_run(UNDERVOLTAGE_LOCKOUT_CYC + DET_CYC + 2);
    #1 check(8'(dim_mode), 8'(m), "mode");
  endtask
  task automatic gate();
    logic prev;
    @(negedge ref_clk) prev = enable_pwm_in;
    repeat (128) begin
      @(negedge ref_clk);
      check(8'(switch_enable), 8'(prev), "gating");
      prev = enable_pwm_in;
    end
  endtask
  task automatic settle_ref(input logic [7:0] exp);
    repeat (640) @(posedge ref_clk);
    #1 check(current_ref_code, exp, "reference");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pwm();
    start(LDMC_MODE_PWM, 8'h03, 8'h00);
    gate();
  endtask
  task automatic t_analog();
    int b;
    logic [5:0] stop_mask;
    stop_mask = 6'h27;
    start(LDMC_MODE_ANALOG, 8'h00, 8'h30);
    settle_ref(8'((48 * 255) / 64));
    for (b = 0; b < 6; b++) begin
      @(posedge ref_clk) fault_vec <= 6'h01 << b;
      repeat (3) @(posedge ref_clk);
      #1 check(8'(fault_n_oe), 8'h00, "fault flag");
      check(8'(switch_enable), 8'(!stop_mask[b]), "fault stop");
      @(posedge ref_clk) fault_vec <= 6'h00;
      repeat (3) @(posedge ref_clk);
      #1 check(8'({fault_n_oe, switch_enable}), 8'h03, "fault recover");
    end
    @(posedge ref_clk) fb_cv <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check(8'(cv_active), 8'h01, "cv entry");
    @(posedge ref_clk) fb_cv <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(8'(cv_active), 8'h00, "cv exit");
    @(posedge ref_clk) go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check(8'({dim_running, switch_enable}), 8'h00, "disabled");
    @(posedge ref_clk) go <= 1'b1;
    wait_run(REEN_CYC + DET_CYC + 2);
    #1 check(8'(dim_mode), 8'(LDMC_MODE_ANALOG), "re-enable mode");
  endtask
  task automatic t_hybrid();
    start(LDMC_MODE_HYBRID, 8'h20, 8'h00);
    settle_ref(8'((32 * 255) / 64));
    check(8'(switch_enable), 8'h01, "hybrid high gate");
    @(posedge ref_clk) en_h <= 8'h04;
    settle_ref(`LDMC_HYB_KNEE);
    gate();
    @(posedge ref_clk) en_h <= 8'h20;
    settle_ref(8'((32 * 255) / 64));
    check(8'(switch_enable), 8'h01, "hybrid back high");
  endtask
  task automatic t_flex();
    start(LDMC_MODE_FLEX, 8'h10, 8'h18);
    settle_ref(8'((24 * 255) / 64));
    gate();
  endtask
  initial begin
    t_pwm();
    t_analog();
    t_hybrid();
    t_flex();
    close_out();
  end
endmodule
